// File: pkg/src_pkg.sv
// Shared constants and types of the system reset controller
package src_pkg;

	// System clock
	localparam int unsigned CLK_PERIOD_NS = 5;

	// Power-on settle delay before the internal reset is released
	localparam int unsigned POR_DELAY_NS = 20000;
	localparam int unsigned POR_DELAY_CYCLES =
		(POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Least low time on the manual reset pin that is taken as a reset
	localparam int unsigned PIN_MIN_PULSE_NS = 100;
	localparam int unsigned PIN_MIN_PULSE_CYCLES =
		(PIN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Least length of a system reset and of a local wake reset
	localparam int unsigned SYS_HOLD_NS = 80;
	localparam int unsigned SYS_HOLD_CYCLES =
		(SYS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOCAL_HOLD_NS = 80;
	localparam int unsigned LOCAL_HOLD_CYCLES =
		(LOCAL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Watchdog tick period in system clocks
	localparam int unsigned WDOG_TICK_DEFAULT = 131072;
	localparam int unsigned WDOG_WIDTH = 8;
	localparam logic [7:0] WDOG_RESET_VAL = 8'h00;
	localparam logic [7:0] WDOG_MAX = 8'hff;

	// Watchdog and reset control register layout
	localparam int unsigned CTRL_SW_RESET_BIT = 0;
	localparam int unsigned CTRL_WDOG_RST_EN_BIT = 1;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'h03;
	localparam logic [7:0] CTRL_RESET_VAL = 8'h00;

	// Registers cleared only by power-on or shutdown wake
	localparam logic [7:0] HOLD_RESET_VAL = 8'h00;
	localparam logic CODE_OFFSET_RESET_VAL = 1'b0;

	// Source of the last reset
	localparam logic [2:0] CAUSE_POWER_ON = 3'h0;
	localparam logic [2:0] CAUSE_PIN = 3'h1;
	localparam logic [2:0] CAUSE_SOFTWARE = 3'h2;
	localparam logic [2:0] CAUSE_WATCHDOG = 3'h3;
	localparam logic [2:0] CAUSE_SHUTDOWN_WAKE = 3'h4;
	localparam logic [2:0] CAUSE_SLEEP_WAKE = 3'h5;

	typedef enum logic [2:0] {
		src_st_por_hold,
		src_st_run,
		src_st_sys_hold,
		src_st_wake_power,
		src_st_sleep_wait,
		src_st_local_hold
	} src_state_t;

endpackage

// File: design/src_input_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
module src_input_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("src_input_sync: WIDTH must be at least 1");
		end
	endgenerate

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic stage1;
			logic stage2;
			logic stage3;
			logic next_level;

			// Stage1 feeds stage2 only; the filter looks at stages two and three
			always_comb begin
				next_level = sync_o[gi];
				if (stage2 == stage3) begin
					next_level = stage3;
				end
			end

			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					stage1 <= IDLE[gi];
					stage2 <= IDLE[gi];
					stage3 <= IDLE[gi];
					sync_o[gi] <= IDLE[gi];
				end else begin
					stage1 <= async_i[gi];
					stage2 <= stage1;
					stage3 <= stage2;
					sync_o[gi] <= next_level;
				end
			end
		end
	endgenerate

endmodule

// File: design/src_reset_controller.sv
// System reset controller: combines six reset sources into system and local resets
`timescale 1ns/1ps
module src_reset_controller import src_pkg::*; #(
	parameter int unsigned POR_HOLD_CYCLES = POR_DELAY_CYCLES,
	parameter int unsigned WDOG_TICK_CYCLES = WDOG_TICK_DEFAULT,
	parameter int unsigned PIN_MIN_CYCLES = PIN_MIN_PULSE_CYCLES
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic reset_n_pin_i,
	input wire logic pin_reset_enable_i,
	input wire logic ctrl_write_i,
	input wire logic [7:0] ctrl_wdata_i,
	input wire logic wdog_write_i,
	input wire logic [7:0] wdog_wdata_i,
	input wire logic hold_write_i,
	input wire logic [7:0] hold_wdata_i,
	input wire logic code_offset_write_i,
	input wire logic code_offset_wdata_i,
	input wire logic shutdown_mode_i,
	input wire logic sleep_mode_i,
	input wire logic wake_i,
	input wire logic aux_power_ready_i,
	output logic system_reset_o,
	output logic retained_key_reset_o,
	output logic regen_reset_o,
	output logic volatile_reset_o,
	output logic [7:0] ctrl_o,
	output logic [7:0] wdog_count_o,
	output logic [7:0] reset_hold_o,
	output logic code_offset_o,
	output logic [2:0] reset_cause_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Widths and elaboration checks

	localparam int unsigned HOLD_MAX0 =
		(POR_HOLD_CYCLES > SYS_HOLD_CYCLES) ? POR_HOLD_CYCLES : SYS_HOLD_CYCLES;
	localparam int unsigned HOLD_MAX =
		(HOLD_MAX0 > LOCAL_HOLD_CYCLES) ? HOLD_MAX0 : LOCAL_HOLD_CYCLES;
	localparam int unsigned HOLD_W = $clog2(HOLD_MAX + 1);
	localparam int unsigned TICK_W = (WDOG_TICK_CYCLES > 1) ? $clog2(WDOG_TICK_CYCLES) : 1;
	localparam int unsigned PIN_W = $clog2(PIN_MIN_CYCLES + 1);

	generate
		if (POR_HOLD_CYCLES < 1 || WDOG_TICK_CYCLES < 2 || PIN_MIN_CYCLES < 1) begin : g_bad
			$error("src_reset_controller: hold, tick and pin counts must be positive");
		end
	endgenerate

	localparam logic [HOLD_W-1:0] POR_LAST = HOLD_W'(POR_HOLD_CYCLES - 1);
	localparam logic [HOLD_W-1:0] SYS_LAST = HOLD_W'(SYS_HOLD_CYCLES - 1);
	localparam logic [HOLD_W-1:0] LOCAL_LAST = HOLD_W'(LOCAL_HOLD_CYCLES - 1);
	localparam logic [HOLD_W-1:0] HOLD_ZERO = '0;
	localparam logic [HOLD_W-1:0] HOLD_ONE = HOLD_W'(1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(WDOG_TICK_CYCLES - 1);
	localparam logic [TICK_W-1:0] TICK_ZERO = '0;
	localparam logic [TICK_W-1:0] TICK_ONE = TICK_W'(1);
	localparam logic [PIN_W-1:0] PIN_FULL = PIN_W'(PIN_MIN_CYCLES);
	localparam logic [PIN_W-1:0] PIN_ZERO = '0;
	localparam logic [PIN_W-1:0] PIN_ONE = PIN_W'(1);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [2:0] async_in;
	logic [2:0] sync_in;
	logic pin_n_sync;
	logic wake_sync;
	logic power_ready_sync;

	assign async_in = {aux_power_ready_i, wake_i, reset_n_pin_i};

	// Pin idles high, wake and ready idle low
	src_input_sync #(
		.WIDTH(3),
		.IDLE(3'h1)
	) u_sync (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.async_i(async_in),
		.sync_o(sync_in)
	);

	assign pin_n_sync = sync_in[0];
	assign wake_sync = sync_in[1];
	assign power_ready_sync = sync_in[2];

	////////////////////////////////////////////////////////////////////////////////
	// Manual pin pulse-width filter

	logic [PIN_W-1:0] pin_count;
	logic [PIN_W-1:0] next_pin_count;
	logic pin_trigger;

	always_comb begin
		next_pin_count = PIN_ZERO;
		if (!pin_n_sync) begin
			next_pin_count = (pin_count == PIN_FULL) ? PIN_FULL : pin_count + PIN_ONE;
		end
	end

	// Short glitches never reach the full count, so they are ignored
	assign pin_trigger = pin_reset_enable_i && (pin_count == PIN_FULL);

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			pin_count <= PIN_ZERO;
		end else begin
			pin_count <= next_pin_count;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer

	src_state_t state;
	src_state_t next_state;
	logic [HOLD_W-1:0] hold_count;
	logic [HOLD_W-1:0] next_hold_count;
	logic [2:0] next_reset_cause;
	logic [TICK_W-1:0] tick_count;
	logic wdog_overflow;
	logic wdog_trigger;
	logic sw_trigger;
	logic shutdown_wake;
	logic sleep_wake;

	assign sw_trigger = ctrl_o[CTRL_SW_RESET_BIT];
	assign wdog_overflow = (tick_count == TICK_LAST) && (wdog_count_o == WDOG_MAX);
	assign wdog_trigger = ctrl_o[CTRL_WDOG_RST_EN_BIT] && wdog_overflow;
	assign shutdown_wake = wake_sync && shutdown_mode_i;
	assign sleep_wake = wake_sync && sleep_mode_i && !shutdown_mode_i;

	always_comb begin
		next_state = state;
		next_hold_count = hold_count + HOLD_ONE;
		next_reset_cause = reset_cause_o;
		unique case (state)
			src_st_por_hold: begin
				if (hold_count == POR_LAST) begin
					next_state = src_st_run;
					next_hold_count = HOLD_ZERO;
				end
			end
			src_st_run: begin
				next_hold_count = HOLD_ZERO;
				// Direct system causes outrank the wake paths
				if (pin_trigger) begin
					next_state = src_st_sys_hold;
					next_reset_cause = CAUSE_PIN;
				end else if (sw_trigger) begin
					next_state = src_st_sys_hold;
					next_reset_cause = CAUSE_SOFTWARE;
				end else if (wdog_trigger) begin
					next_state = src_st_sys_hold;
					next_reset_cause = CAUSE_WATCHDOG;
				end else if (shutdown_wake) begin
					next_state = src_st_wake_power;
					next_reset_cause = CAUSE_SHUTDOWN_WAKE;
				end else if (sleep_wake) begin
					next_state = src_st_sleep_wait;
					next_reset_cause = CAUSE_SLEEP_WAKE;
				end
			end
			src_st_sys_hold: begin
				// A pin still held low with pin reset enabled keeps the system in reset
				if (hold_count >= SYS_LAST) begin
					next_hold_count = SYS_LAST;
					if (!(pin_reset_enable_i && !pin_n_sync)) begin
						next_state = src_st_run;
						next_hold_count = HOLD_ZERO;
					end
				end
			end
			src_st_wake_power: begin
				next_hold_count = HOLD_ZERO;
				// Wake steps first, then the same path as power-on
				if (power_ready_sync) begin
					next_state = src_st_por_hold;
				end
			end
			src_st_sleep_wait: begin
				next_hold_count = HOLD_ZERO;
				if (power_ready_sync) begin
					next_state = src_st_local_hold;
				end
			end
			src_st_local_hold: begin
				if (hold_count == LOCAL_LAST) begin
					next_state = src_st_run;
					next_hold_count = HOLD_ZERO;
				end
			end
		endcase
	end

	// Reset domains follow the next state so every output flips on one edge
	logic next_system_reset;
	logic next_local_reset;

	always_comb begin
		next_system_reset = (next_state == src_st_por_hold) ||
			(next_state == src_st_sys_hold) || (next_state == src_st_wake_power);
		next_local_reset = (next_state == src_st_sleep_wait) ||
			(next_state == src_st_local_hold);
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state <= src_st_por_hold;
			hold_count <= HOLD_ZERO;
			reset_cause_o <= CAUSE_POWER_ON;
			system_reset_o <= 1'b1;
			retained_key_reset_o <= 1'b1;
			regen_reset_o <= 1'b1;
			volatile_reset_o <= 1'b1;
		end else begin
			state <= next_state;
			hold_count <= next_hold_count;
			reset_cause_o <= next_reset_cause;
			system_reset_o <= next_system_reset;
			retained_key_reset_o <= next_system_reset;
			regen_reset_o <= next_system_reset || next_local_reset;
			volatile_reset_o <= next_system_reset || next_local_reset;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog and control register

	logic [TICK_W-1:0] next_tick_count;
	logic [7:0] next_wdog_count;
	logic [7:0] next_ctrl;
	logic in_system_reset;

	assign in_system_reset = (state == src_st_por_hold) || (state == src_st_sys_hold) ||
		(state == src_st_wake_power);

	always_comb begin
		next_tick_count = tick_count;
		next_wdog_count = wdog_count_o;
		next_ctrl = ctrl_o;
		if (in_system_reset || next_system_reset) begin
			// Leaving run for a system reset also drops the software bit
			next_tick_count = TICK_ZERO;
			next_wdog_count = WDOG_RESET_VAL;
			next_ctrl = CTRL_RESET_VAL;
		end else if (state == src_st_run) begin
			next_tick_count = (tick_count == TICK_LAST) ? TICK_ZERO : tick_count + TICK_ONE;
			if (tick_count == TICK_LAST) begin
				next_wdog_count = wdog_count_o + 8'h01;
			end
			if (wdog_write_i) begin
				next_wdog_count = wdog_wdata_i;
			end
			if (ctrl_write_i) begin
				next_ctrl = ctrl_wdata_i & CTRL_WRITE_MASK;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			tick_count <= TICK_ZERO;
			wdog_count_o <= WDOG_RESET_VAL;
			ctrl_o <= CTRL_RESET_VAL;
		end else begin
			tick_count <= next_tick_count;
			wdog_count_o <= next_wdog_count;
			ctrl_o <= next_ctrl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers kept across all but power-on and shutdown-wake resets

	logic [7:0] next_reset_hold;
	logic next_code_offset;

	always_comb begin
		next_reset_hold = reset_hold_o;
		next_code_offset = code_offset_o;
		if (state == src_st_por_hold) begin
			next_reset_hold = HOLD_RESET_VAL;
			next_code_offset = CODE_OFFSET_RESET_VAL;
		end else begin
			if (hold_write_i) begin
				next_reset_hold = hold_wdata_i;
			end
			if (code_offset_write_i) begin
				next_code_offset = code_offset_wdata_i;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			reset_hold_o <= HOLD_RESET_VAL;
			code_offset_o <= CODE_OFFSET_RESET_VAL;
		end else begin
			reset_hold_o <= next_reset_hold;
			code_offset_o <= next_code_offset;
		end
	end

endmodule

// File: bench/src_rc_props.sv
// Concurrent checks on the ports of the system reset controller
`timescale 1ns/1ps
module src_rc_props import src_pkg::*; #(
	parameter int unsigned POR_HOLD_CYCLES = 8,
	parameter int unsigned WDOG_TICK_CYCLES = 4,
	parameter int unsigned PIN_MIN_CYCLES = 3
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic reset_n_pin_i,
	input wire logic pin_reset_enable_i,
	input wire logic ctrl_write_i,
	input wire logic [7:0] ctrl_wdata_i,
	input wire logic wdog_write_i,
	input wire logic [7:0] wdog_wdata_i,
	input wire logic shutdown_mode_i,
	input wire logic sleep_mode_i,
	input wire logic wake_i,
	input wire logic system_reset_o,
	input wire logic retained_key_reset_o,
	input wire logic regen_reset_o,
	input wire logic volatile_reset_o,
	input wire logic [7:0] ctrl_o,
	input wire logic [7:0] wdog_count_o,
	input wire logic [7:0] reset_hold_o,
	input wire logic code_offset_o,
	input wire logic [2:0] reset_cause_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// Length of the current system reset, saturating so long holds cannot wrap
	logic [7:0] high_run;
	logic [7:0] next_high_run;
	always_comb begin
		next_high_run = 8'h00;
		if (system_reset_o) begin
			next_high_run = (high_run == 8'hff) ? high_run : high_run + 8'h01;
		end
	end
	always_ff @(posedge clock_i) begin
		high_run <= reset_i ? 8'h00 : next_high_run;
	end
	////////////////////////////////////////////////////////////////////////
	sequence s_por_hold;
		system_reset_o[*6] ##[1:4] !system_reset_o;
	endsequence
	sequence s_pin_held;
		(!reset_n_pin_i && pin_reset_enable_i)[*8];
	endsequence
	property p_por;
		$fell(reset_i) |-> s_por_hold;
	endproperty
	a_por: assert property (p_por) else $error("power-on hold length");
	property p_clear;
		$fell(reset_i) |-> reset_hold_o == HOLD_RESET_VAL && !code_offset_o
			&& ctrl_o == CTRL_RESET_VAL && wdog_count_o == WDOG_RESET_VAL;
	endproperty
	a_clear: assert property (p_clear) else $error("power-on clear");
	property p_tree;
		retained_key_reset_o == system_reset_o && volatile_reset_o == regen_reset_o
			&& (regen_reset_o || !system_reset_o);
	endproperty
	a_tree: assert property (p_tree) else $error("reset tree");
	property p_sw;
		ctrl_write_i && ctrl_wdata_i[CTRL_SW_RESET_BIT] && !system_reset_o && !regen_reset_o
			|-> ##2 system_reset_o;
	endproperty
	a_sw: assert property (p_sw) else $error("software reset");
	property p_hold_len;
		$fell(system_reset_o) && reset_cause_o != CAUSE_POWER_ON
			&& reset_cause_o != CAUSE_SHUTDOWN_WAKE |-> high_run >= 8'h0f;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("system reset too short");
	property p_freeze;
		$past(regen_reset_o) && !$past(system_reset_o) && regen_reset_o && !system_reset_o
			|-> $stable(wdog_count_o) && $stable(reset_hold_o) && $stable(ctrl_o);
	endproperty
	a_freeze: assert property (p_freeze) else $error("local reset touched kept state");
	property p_preset;
		wdog_write_i && !system_reset_o && !regen_reset_o
			|=> system_reset_o || wdog_count_o == $past(wdog_wdata_i);
	endproperty
	a_preset: assert property (p_preset) else $error("watchdog preset");
	property p_step;
		!system_reset_o && !$past(wdog_write_i) && wdog_count_o != $past(wdog_count_o)
			|-> wdog_count_o == $past(wdog_count_o) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("watchdog step");
	property p_overflow;
		ctrl_o[CTRL_WDOG_RST_EN_BIT] && wdog_count_o == WDOG_MAX && !system_reset_o
			&& !regen_reset_o
			|-> ##[1:6] system_reset_o;
	endproperty
	a_overflow: assert property (p_overflow) else $error("watchdog overflow");
	property p_pin;
		s_pin_held |-> ##[0:3] system_reset_o;
	endproperty
	a_pin: assert property (p_pin) else $error("manual pin reset");
	property p_sleep;
		wake_i && sleep_mode_i && !shutdown_mode_i && !regen_reset_o
			|-> ##[1:8] (regen_reset_o && !system_reset_o);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep wake reset");
	property p_shut_clear;
		$fell(system_reset_o) && reset_cause_o == CAUSE_SHUTDOWN_WAKE
			|-> reset_hold_o == HOLD_RESET_VAL && code_offset_o == CODE_OFFSET_RESET_VAL;
	endproperty
	a_shut_clear: assert property (p_shut_clear) else $error("shutdown wake clear");
endmodule

bind src_reset_controller src_rc_props #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES),
	.WDOG_TICK_CYCLES(WDOG_TICK_CYCLES), .PIN_MIN_CYCLES(PIN_MIN_CYCLES)) u_props (
	.clock_i(clock_i), .reset_i(reset_i), .reset_n_pin_i(reset_n_pin_i),
	.pin_reset_enable_i(pin_reset_enable_i), .ctrl_write_i(ctrl_write_i),
	.ctrl_wdata_i(ctrl_wdata_i), .wdog_write_i(wdog_write_i), .wdog_wdata_i(wdog_wdata_i),
	.shutdown_mode_i(shutdown_mode_i), .sleep_mode_i(sleep_mode_i), .wake_i(wake_i),
	.system_reset_o(system_reset_o), .retained_key_reset_o(retained_key_reset_o),
	.regen_reset_o(regen_reset_o), .volatile_reset_o(volatile_reset_o), .ctrl_o(ctrl_o),
	.wdog_count_o(wdog_count_o), .reset_hold_o(reset_hold_o),
	.code_offset_o(code_offset_o), .reset_cause_o(reset_cause_o));

// File: bench/src_supply_model.sv
// Manual reset pin and supply monitor on the far side of the controller
`timescale 1ns/1ps
module src_supply_model (
	input wire logic clock_i,
	output logic reset_o,
	output logic reset_n_pin_o,
	output logic aux_power_ready_o
);
	initial begin
		reset_o = 1'b1;
		reset_n_pin_o = 1'b1;
		aux_power_ready_o = 1'b1;
		repeat (10) @(posedge clock_i);
		#1;
		reset_o = 1'b0;
	end
	// Whole cycles low; pulses below the least width are allowed so refusal can be seen
	task automatic press(input int n);
		reset_n_pin_o = 1'b0;
		repeat (n) @(posedge clock_i);
		#1;
		reset_n_pin_o = 1'b1;
	endtask
	task automatic set_ready(input logic v);
		aux_power_ready_o = v;
	endtask
endmodule

// File: bench/tb.sv
// Self-checking testbench of the system reset controller
`timescale 1ns/1ps
module tb import src_pkg::*;;
	logic clock_i;
	logic reset_i, reset_n_pin_i, aux_power_ready_i;
	logic pin_reset_enable_i;
	logic ctrl_write_i, wdog_write_i, hold_write_i;
	logic code_offset_write_i, code_offset_wdata_i;
	logic [7:0] ctrl_wdata_i, wdog_wdata_i, hold_wdata_i;
	logic shutdown_mode_i, sleep_mode_i, wake_i;
	logic system_reset_o, retained_key_reset_o, regen_reset_o, volatile_reset_o;
	logic [7:0] ctrl_o, wdog_count_o, reset_hold_o;
	logic code_offset_o;
	logic [2:0] reset_cause_o;
	int n_mismatch = 0;
	int cmp_count = 0;
	src_supply_model model (.clock_i(clock_i), .reset_o(reset_i),
		.reset_n_pin_o(reset_n_pin_i), .aux_power_ready_o(aux_power_ready_i));
	src_reset_controller #(.POR_HOLD_CYCLES(8), .WDOG_TICK_CYCLES(4), .PIN_MIN_CYCLES(3)) dut (
		.clock_i(clock_i), .reset_i(reset_i), .reset_n_pin_i(reset_n_pin_i),
		.pin_reset_enable_i(pin_reset_enable_i), .ctrl_write_i(ctrl_write_i),
		.ctrl_wdata_i(ctrl_wdata_i), .wdog_write_i(wdog_write_i), .wdog_wdata_i(wdog_wdata_i),
		.hold_write_i(hold_write_i), .hold_wdata_i(hold_wdata_i),
		.code_offset_write_i(code_offset_write_i), .code_offset_wdata_i(code_offset_wdata_i),
		.shutdown_mode_i(shutdown_mode_i), .sleep_mode_i(sleep_mode_i), .wake_i(wake_i),
		.aux_power_ready_i(aux_power_ready_i), .system_reset_o(system_reset_o),
		.retained_key_reset_o(retained_key_reset_o), .regen_reset_o(regen_reset_o),
		.volatile_reset_o(volatile_reset_o), .ctrl_o(ctrl_o), .wdog_count_o(wdog_count_o),
		.reset_hold_o(reset_hold_o), .code_offset_o(code_offset_o),
		.reset_cause_o(reset_cause_o));
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic chk(input bit ok, input string msg);
		cmp_count++;
		if (!ok) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic tally_and_finish;
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Selector 0 control, 1 watchdog, 2 hold, 3 code offset; one-cycle strobe
	// An idle edge follows so back-to-back calls never rewrite a strobe in one step
	task automatic wr(input int sel, input logic [7:0] d);
		ctrl_wdata_i = d;
		wdog_wdata_i = d;
		hold_wdata_i = d;
		code_offset_wdata_i = d[0];
		ctrl_write_i = (sel == 0);
		wdog_write_i = (sel == 1);
		hold_write_i = (sel == 2);
		code_offset_write_i = (sel == 3);
		tick(1);
		ctrl_write_i = 1'b0;
		wdog_write_i = 1'b0;
		hold_write_i = 1'b0;
		code_offset_write_i = 1'b0;
		tick(1);
	endtask
	// Selector 0 system reset, 1 local reset, 2 watchdog count
	task automatic wait_for(input int sel, input logic [7:0] exp);
		int i;
		for (i = 0; i < 500; i++) begin
			if ((sel == 0 ? {7'h00, system_reset_o} : sel == 1 ? {7'h00, regen_reset_o}
				: wdog_count_o) === exp) break;
			tick(1);
		end
		chk(i < 500, "wait limit");
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_por;
		chk(system_reset_o === 1'b1 && reset_cause_o === CAUSE_POWER_ON, "por hold");
		chk(reset_hold_o === 8'h00 && code_offset_o === 1'b0 && ctrl_o === 8'h00, "por");
		wait_for(0, 8'h00);
	endtask
	task automatic t_sw;
		wr(2, 8'ha5);
		wr(3, 8'h01);
		wr(0, 8'h01);
		wait_for(0, 8'h01);
		chk(reset_cause_o === CAUSE_SOFTWARE && ctrl_o[0] === 1'b0, "sw reset");
		wait_for(0, 8'h00);
		chk(reset_hold_o === 8'ha5 && code_offset_o === 1'b1, "kept after sw");
	endtask
	task automatic t_pin;
		model.press(12);
		tick(30);
		chk(system_reset_o === 1'b0, "pin disabled");
		pin_reset_enable_i = 1'b1;
		model.press(2);
		tick(30);
		chk(system_reset_o === 1'b0, "short pulse");
		model.press(12);
		chk(system_reset_o === 1'b1 && reset_cause_o === CAUSE_PIN, "pin reset");
		wait_for(0, 8'h00);
		chk(reset_hold_o === 8'ha5, "kept after pin");
	endtask
	task automatic t_wdog;
		wr(1, 8'hfd);
		wait_for(2, 8'h00);
		wait_for(2, 8'h02);
		tick(3);
		chk(wdog_count_o === 8'h02 && system_reset_o === 1'b0, "tick early");
		tick(1);
		chk(wdog_count_o === 8'h03, "tick period");
		wr(0, 8'h02);
		wr(1, 8'hfe);
		wait_for(0, 8'h01);
		chk(reset_cause_o === CAUSE_WATCHDOG && wdog_count_o === 8'h00, "wdog reset");
		wait_for(0, 8'h00);
	endtask
	task automatic t_sleep;
		wr(0, 8'h00);
		wr(2, 8'h3c);
		model.set_ready(1'b0);
		sleep_mode_i = 1'b1;
		wake_i = 1'b1;
		wait_for(1, 8'h01);
		chk(system_reset_o === 1'b0 && retained_key_reset_o === 1'b0
			&& volatile_reset_o === 1'b1, "local only");
		wake_i = 1'b0;
		sleep_mode_i = 1'b0;
		tick(20);
		chk(regen_reset_o === 1'b1, "waits for supply");
		model.set_ready(1'b1);
		wait_for(1, 8'h00);
		chk(reset_hold_o === 8'h3c && reset_cause_o === CAUSE_SLEEP_WAKE, "retained");
	endtask
	task automatic t_shut;
		model.set_ready(1'b0);
		shutdown_mode_i = 1'b1;
		wake_i = 1'b1;
		wait_for(0, 8'h01);
		wake_i = 1'b0;
		shutdown_mode_i = 1'b0;
		model.set_ready(1'b1);
		wait_for(0, 8'h00);
		chk(reset_hold_o === 8'h00 && code_offset_o === 1'b0
			&& reset_cause_o === CAUSE_SHUTDOWN_WAKE, "shutdown wake");
	endtask
	initial begin
		pin_reset_enable_i = 1'b0;
		ctrl_write_i = 1'b0;
		wdog_write_i = 1'b0;
		hold_write_i = 1'b0;
		code_offset_write_i = 1'b0;
		code_offset_wdata_i = 1'b0;
		ctrl_wdata_i = 8'h00;
		wdog_wdata_i = 8'h00;
		hold_wdata_i = 8'h00;
		shutdown_mode_i = 1'b0;
		sleep_mode_i = 1'b0;
		wake_i = 1'b0;
		wait (reset_i === 1'b0);
		tick(1);
		t_por;
		t_sw;
		t_pin;
		t_wdog;
		t_sleep;
		t_shut;
		tally_and_finish;
	end
	// The whole sequence needs well under a thousand cycles; forty thousand is a wide margin
	initial begin
		#200000;
		n_mismatch++;
		tally_and_finish;
	end
endmodule
